//--- design/rsl_sync_loop_cfg.v
// rsl_sync_loop_cfg: calibration control, frequency offset and bit
// synchronisation configuration registers behind an AXI4-Lite slave.
// assumes: radio state pulses, sync and carrier detect are on aclk.
`timescale 1ns/1ps
`include "rsl_defines.vh"

module rsl_sync_loop_cfg (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire idle_to_active,
    input wire auto_return_to_idle,
    input wire sync_found,
    input wire carrier_detect,
    output reg synth_cal_start_r,
    output reg [3:0] freq_gain_r,
    output reg [1:0] freq_comp_saturation_r,
    output reg [3:0] clkrec_integral_gain_r,
    output reg [3:0] clkrec_proportional_gain_r,
    output reg [1:0] rate_comp_saturation_r,
    output reg loops_frozen_r
);

    // register storage
    reg [7:0] synth_calibration_control_r;
    reg [7:0] freq_offset_comp_config_r;
    reg [7:0] bit_sync_config_r;
    reg manual_calibration_strobe_r;
    // freeze request, first of two stages so the flag lines up with the gains
    reg frozen_q_r;
    // write channel holding
    reg aw_held_r;
    reg w_held_r;
    reg [31:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;

    wire cal_pulse;
    wire [1:0] ret_count;
    wire [3:0] fg;
    wire [3:0] kig;
    wire [3:0] kpg;
    wire frozen_now;
    wire do_write;
    wire [2:0] wsel;
    wire [2:0] rsel;

    // ======================================================================
    // address decode, used for both read and write
    // 0 unmapped, 1 cal, 2 freq, 3 bit sync, 4 ctrl, 5 status
    function [2:0] dec;
        input [31:0] a;
        begin
            case (a[`RSL_ADDR_W-1:0])
                `RSL_ADDR_CALCTL: dec = 3'h1;
                `RSL_ADDR_FOC: dec = 3'h2;
                `RSL_ADDR_BSC: dec = 3'h3;
                `RSL_ADDR_CTRL: dec = 3'h4;
                `RSL_ADDR_STAT: dec = 3'h5;
                default: dec = 3'h0;
            endcase
            if (a[31:`RSL_ADDR_W] != {(32-`RSL_ADDR_W){1'b0}}) begin
                dec = 3'h0;
            end
        end
    endfunction

    assign wsel = dec(awaddr_r);
    assign rsel = dec(s_axi_araddr);
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

    // ======================================================================
    // write address and data taken independently, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 32'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSL_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                aw_held_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_held_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == 3'h0) ? `RSL_RESP_SLVERR : `RSL_RESP_OKAY;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
            // ready again only once the response is accepted
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ======================================================================
    // register update; only byte lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            synth_calibration_control_r <= `RSL_RST_CALCTL;
            freq_offset_comp_config_r <= `RSL_RST_FOC;
            bit_sync_config_r <= `RSL_RST_BSC;
            manual_calibration_strobe_r <= 1'b0;
        end else begin
            manual_calibration_strobe_r <= 1'b0;
            if (do_write && wstrb_r[0]) begin
                case (wsel)
                    3'h1: synth_calibration_control_r <= wdata_r[7:0] & `RSL_MASK_CALCTL;
                    3'h2: freq_offset_comp_config_r <= wdata_r[7:0] & `RSL_MASK_FOC;
                    3'h3: bit_sync_config_r <= wdata_r[7:0] & `RSL_MASK_BSC;
                    3'h4: manual_calibration_strobe_r <= wdata_r[`RSL_CTRL_STROBE];
                    default: manual_calibration_strobe_r <= 1'b0;
                endcase
            end
        end
    end

    // ======================================================================
    // read channel, one outstanding read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RSL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RSL_RESP_OKAY;
            case (rsel)
                3'h1: s_axi_rdata <= {24'h0, synth_calibration_control_r};
                3'h2: s_axi_rdata <= {24'h0, freq_offset_comp_config_r};
                3'h3: s_axi_rdata <= {24'h0, bit_sync_config_r};
                3'h4: s_axi_rdata <= 32'h0;
                // status: live loop and calibration state
                3'h5: s_axi_rdata <= {28'h0, loops_frozen_r, sync_found, ret_count};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `RSL_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ======================================================================
    // calibration trigger
    // select codes map onto the modes
    rsl_cal_trigger u_cal (
        .aclk(aclk),
        .aresetn(aresetn),
        .auto_calibration_select(
            synth_calibration_control_r[`RSL_AUTOCAL_HI:`RSL_AUTOCAL_LO]),
        .manual_calibration_strobe(manual_calibration_strobe_r),
        .idle_to_active(idle_to_active),
        .auto_return_to_idle(auto_return_to_idle),
        .cal_start_r(cal_pulse),
        .return_count_r(ret_count)
    );

    // ======================================================================
    // loop freeze: gate set and no carrier yet; carrier detect is
    // produced upstream from the strength thresholds
    // freeze until carrier
    assign frozen_now = freq_offset_comp_config_r[`RSL_FOC_GATE] && !carrier_detect;

    // frequency gain, K/2 = 1 half unit
    rsl_loop_gain u_fg (
        .aclk(aclk),
        .aresetn(aresetn),
        .pre_code(freq_offset_comp_config_r[`RSL_FOC_PRE_HI:`RSL_FOC_PRE_LO]),
        .post_bit(freq_offset_comp_config_r[`RSL_FOC_POST]),
        .sync_found(sync_found),
        .post_value(4'h1),
        .frozen(frozen_now),
        .gain_r(fg)
    );

    rsl_loop_gain u_ki (
        .aclk(aclk),
        .aresetn(aresetn),
        .pre_code(bit_sync_config_r[`RSL_BS_KI_HI:`RSL_BS_KI_LO]),
        .post_bit(bit_sync_config_r[`RSL_CLKREC_INTEGRAL_POSTSYNC]),
        .sync_found(sync_found),
        .post_value(4'h1),
        .frozen(frozen_now),
        .gain_r(kig)
    );

    rsl_loop_gain u_kp (
        .aclk(aclk),
        .aresetn(aresetn),
        .pre_code(bit_sync_config_r[`RSL_BS_KP_HI:`RSL_BS_KP_LO]),
        .post_bit(bit_sync_config_r[`RSL_CLKREC_PROPORTIONAL_POSTSYNC]),
        .sync_found(sync_found),
        .post_value(4'h2),
        .frozen(frozen_now),
        .gain_r(kpg)
    );

    // ======================================================================
    // output registers; limits pass the codes, 00 meaning off
    always @(posedge aclk) begin
        if (!aresetn) begin
            synth_cal_start_r <= 1'b0;
            freq_gain_r <= 4'h0;
            clkrec_integral_gain_r <= 4'h0;
            clkrec_proportional_gain_r <= 4'h0;
            freq_comp_saturation_r <= 2'h0;
            rate_comp_saturation_r <= 2'h0;
            frozen_q_r <= 1'b0;
            loops_frozen_r <= 1'b0;
        end else begin
            synth_cal_start_r <= cal_pulse;
            freq_gain_r <= fg;
            clkrec_integral_gain_r <= kig;
            clkrec_proportional_gain_r <= kpg;
            freq_comp_saturation_r <= freq_offset_comp_config_r[1:0];
            rate_comp_saturation_r <= bit_sync_config_r[1:0];
            // freeze flag
            // gains take two edges from frozen_now; one stage only would let
            // the flag rise while a stale nonzero gain is still on the pins
            frozen_q_r <= frozen_now;
            loops_frozen_r <= frozen_q_r;
        end
    end

endmodule // rsl_sync_loop_cfg

//--- design/rsl_defines.vh
// rsl_defines.vh: offsets, field positions, reset values and calibration modes
// for the radio sync-loop configuration block.
// assumes: included by bare name from the rsl_sync_loop_cfg and rsl_cal_trigger design files of this block.
`ifndef RSL_DEFINES_VH
`define RSL_DEFINES_VH

// ==========================================================================
// register indices (printed offsets are not all multiples of four)
`define RSL_IDX_CALCTL 16'hDF14
`define RSL_IDX_FOC 16'hDF15
`define RSL_IDX_BSC 16'hDF16
`define RSL_IDX_CTRL 16'hDF20
`define RSL_IDX_STAT 16'hDF21
// byte address is four times the index, low 18 bits kept
`define RSL_ADDR_W 18
`define RSL_ADDR_CALCTL 18'h37C50
`define RSL_ADDR_FOC 18'h37C54
`define RSL_ADDR_BSC 18'h37C58
`define RSL_ADDR_CTRL 18'h37C80
`define RSL_ADDR_STAT 18'h37C84

// ==========================================================================
// reset values
`define RSL_RST_CALCTL 8'h04
`define RSL_RST_FOC 8'h76
`define RSL_RST_BSC 8'h6C
// writable masks; unused bits read zero
`define RSL_MASK_CALCTL 8'h3F
`define RSL_MASK_FOC 8'h7F
`define RSL_MASK_BSC 8'hFF

// ==========================================================================
// field positions
`define RSL_AUTOCAL_HI 5
`define RSL_AUTOCAL_LO 4
`define RSL_FOC_GATE 5
`define RSL_FOC_PRE_HI 4
`define RSL_FOC_PRE_LO 3
`define RSL_FOC_POST 2
`define RSL_BS_KI_HI 7
`define RSL_BS_KI_LO 6
`define RSL_BS_KP_HI 5
`define RSL_BS_KP_LO 4
`define RSL_CLKREC_INTEGRAL_POSTSYNC 3
`define RSL_CLKREC_PROPORTIONAL_POSTSYNC 2
`define RSL_CTRL_STROBE 0

// ==========================================================================
// calibration modes
`define RSL_CAL_NEVER 2'h0
`define RSL_CAL_ON_START 2'h1
`define RSL_CAL_ON_RETURN 2'h2
`define RSL_CAL_EVERY4 2'h3
`define RSL_RETURNS_PER_CAL 2'h3

// ==========================================================================
// AXI responses
`define RSL_RESP_OKAY 2'h0
`define RSL_RESP_SLVERR 2'h2

`endif

//--- design/rsl_cal_trigger.v
// rsl_cal_trigger: decides when the synthesizer is calibrated.
// assumes: state-change pulses are one-cycle and come from the radio
// control machine on aclk.
`timescale 1ns/1ps
`include "rsl_defines.vh"

module rsl_cal_trigger (
    input wire aclk,
    input wire aresetn,
    input wire [1:0] auto_calibration_select,
    input wire manual_calibration_strobe,
    input wire idle_to_active,
    input wire auto_return_to_idle,
    output reg cal_start_r,
    output reg [1:0] return_count_r
);

    reg [1:0] return_count_nxt;
    reg cal_nxt;

    // ======================================================================
    // trigger decode
    always @* begin
        return_count_nxt = return_count_r;
        cal_nxt = manual_calibration_strobe;
        case (auto_calibration_select)
            `RSL_CAL_NEVER: cal_nxt = manual_calibration_strobe;
            `RSL_CAL_ON_START: cal_nxt = manual_calibration_strobe | idle_to_active;
            `RSL_CAL_ON_RETURN: cal_nxt = manual_calibration_strobe | auto_return_to_idle;
            `RSL_CAL_EVERY4: begin
                if (auto_return_to_idle) begin
                    return_count_nxt = return_count_r + 2'h1;
                    if (return_count_r == `RSL_RETURNS_PER_CAL) begin
                        cal_nxt = 1'b1;
                    end
                end
            end
            default: cal_nxt = manual_calibration_strobe;
        endcase
    end

    // ======================================================================
    // registers; the counter keeps its count across mode changes
    always @(posedge aclk) begin
        if (!aresetn) begin
            cal_start_r <= 1'b0;
            return_count_r <= 2'h0;
        end else begin
            cal_start_r <= cal_nxt;
            return_count_r <= return_count_nxt;
        end
    end

endmodule // rsl_cal_trigger

//--- design/rsl_loop_gain.v
// rsl_loop_gain: one loop gain selector, pre-sync multiple 1..4 of base,
// post-sync either unchanged or replaced by a fixed value.
// assumes: gains are expressed in half units of the base gain.
`timescale 1ns/1ps

module rsl_loop_gain (
    input wire aclk,
    input wire aresetn,
    input wire [1:0] pre_code,
    input wire post_bit,
    input wire sync_found,
    input wire [3:0] post_value,
    input wire frozen,
    output reg [3:0] gain_r
);

    // ======================================================================
    // code n gives (n+1)*base, i.e. 2*(n+1) half units; frozen forces zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            gain_r <= 4'h0;
        end else if (frozen) begin
            gain_r <= 4'h0;
        end else if (sync_found && post_bit) begin
            gain_r <= post_value;
        end else begin
            gain_r <= {1'b0, pre_code, 1'b0} + 4'h2;
        end
    end

endmodule // rsl_loop_gain

//--- tb/rsl_cfg_props.sv
// rsl_cfg_props: port-level checks of the sync-loop configuration block.
// assumes: bound onto rsl_sync_loop_cfg, everything on aclk.
`timescale 1ns/1ps

module rsl_cfg_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire idle_to_active,
    input wire auto_return_to_idle,
    input wire carrier_detect,
    input wire synth_cal_start_r,
    input wire [3:0] freq_gain_r,
    input wire [3:0] clkrec_integral_gain_r,
    input wire [3:0] clkrec_proportional_gain_r,
    input wire loops_frozen_r
);
    // ==========================================================
    // helper: short window after any calibration cause
    reg bv_q_r;
    reg [2:0] cause_cnt_r;
    always @(posedge aclk) begin
        bv_q_r <= s_axi_bvalid;
        if (!aresetn)
            cause_cnt_r <= 3'h0;
        else if (idle_to_active || auto_return_to_idle || (s_axi_bvalid && !bv_q_r))
            cause_cnt_r <= 3'h6;
        else if (cause_cnt_r != 3'h0)
            cause_cnt_r <= cause_cnt_r - 3'h1;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // bus handshakes
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    // both channels taken together: held at that edge, response one edge later
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write response");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");

    // ==========================================================
    // carrier releases the loops; frozen gains, legal gain values, calibration causes
    chk_freeze_release: assert property (
        carrier_detect [*3] |=> !loops_frozen_r) else $error("loops frozen under carrier");
    chk_frozen_zero: assert property (
        loops_frozen_r |-> (freq_gain_r | clkrec_integral_gain_r
        | clkrec_proportional_gain_r) == 4'h0) else $error("gain while frozen");
    chk_gain_legal: assert property (
        freq_gain_r inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8}) else $error("bad gain");
    chk_cal_cause: assert property (
        synth_cal_start_r |-> cause_cnt_r != 3'h0) else $error("calibration without cause");
endmodule // rsl_cfg_props

bind rsl_sync_loop_cfg rsl_cfg_props i_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .idle_to_active(idle_to_active), .auto_return_to_idle(auto_return_to_idle),
    .carrier_detect(carrier_detect), .synth_cal_start_r(synth_cal_start_r),
    .freq_gain_r(freq_gain_r), .clkrec_integral_gain_r(clkrec_integral_gain_r),
    .clkrec_proportional_gain_r(clkrec_proportional_gain_r),
    .loops_frozen_r(loops_frozen_r)
);

//--- tb/test_rsl_sync_loop_cfg.sv
// test_rsl_sync_loop_cfg: self-checking bench of the sync-loop config block.
// assumes: the block alone on aclk; the bench is the AXI4-Lite master.
`timescale 1ns/1ps
`include "rsl_defines.vh"

module test_rsl_sync_loop_cfg;
    localparam [31:0] A_CAL = {14'h0, `RSL_ADDR_CALCTL};
    localparam [31:0] A_FOC = {14'h0, `RSL_ADDR_FOC};
    localparam [31:0] A_BSC = {14'h0, `RSL_ADDR_BSC};
    localparam [31:0] A_CTL = {14'h0, `RSL_ADDR_CTRL};
    localparam [31:0] A_STAT = {14'h0, `RSL_ADDR_STAT};
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
    reg [3:0] wstrb = 4'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg i2a = 1'b0, ret = 1'b0, sync = 1'b0, cd = 1'b0;
    reg [1:0] resp;
    reg [7:0] foc, bsc;
    wire awready, wready, bvalid, arready, rvalid, cal, frz;
    wire [1:0] bresp, rresp, fsat, rsat;
    wire [31:0] rdata;
    wire [3:0] fg, kig, kpg;
    integer fails = 0, n_compared = 0, cyc = 0, n_cal = 0, m, k;

    rsl_sync_loop_cfg i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .idle_to_active(i2a), .auto_return_to_idle(ret), .sync_found(sync),
        .carrier_detect(cd), .synth_cal_start_r(cal), .freq_gain_r(fg),
        .freq_comp_saturation_r(fsat), .clkrec_integral_gain_r(kig),
        .clkrec_proportional_gain_r(kpg), .rate_comp_saturation_r(rsat),
        .loops_frozen_r(frz)
    );

    // ==========================================================
    // clock, calibration pulse count, hang guard
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cal === 1'b1)
            n_cal <= n_cal + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            stop_test;
        end
    end

    // ==========================================================
    // tasks
    task stop_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // response is taken late on purpose so that bvalid has to stand
    task wr(input [31:0] a, input [31:0] d, input [3:0] s);
        begin
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
            end while (bvalid !== 1'b1);
            repeat ($urandom % 3) @(posedge aclk);
            bready <= 1'b1;
            @(posedge aclk);
            resp = bresp;
            bready <= 1'b0;
        end
    endtask

    task rdr(input [31:0] a);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            do begin
                @(posedge aclk);
                if (arready)
                    arvalid <= 1'b0;
            end while (rvalid !== 1'b1);
            repeat ($urandom % 3) @(posedge aclk);
            rready <= 1'b1;
            @(posedge aclk);
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
        end
    endtask

    // one radio event, then room for the calibration to land
    task pulse(input sel);
        begin
            if (sel)
                ret <= 1'b1;
            else
                i2a <= 1'b1;
            @(posedge aclk);
            ret <= 1'b0;
            i2a <= 1'b0;
            repeat (7) @(posedge aclk);
        end
    endtask

    // gain in half units of the base gain
    function [3:0] eg(input [1:0] pre, input post, input [3:0] pv, input s, input f);
        begin
            if (f)
                eg = 4'h0;
            else if (s && post)
                eg = pv;
            else
                eg = ({2'b00, pre} + 4'h1) * 4'h2;
        end
    endfunction

    // ==========================================================
    // main sequence
    initial begin
        k = $urandom(68);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(frz, 1'b1);
        chk(fsat, 2'h2);
        chk(rsat, 2'h0);
        rdr(A_CAL);
        chk(rd, 32'h04);
        rdr(A_FOC);
        chk(rd, 32'h76);
        rdr(A_BSC);
        chk(rd, 32'h6C);
        // software keeps reserved low bits at 0100 and frequency bit 6 at zero
        wr(A_CAL, 32'hFFFFFFF4, 4'hF);
        rdr(A_CAL);
        chk(rd, 32'h34);
        wr(A_FOC, 32'hFFFFFFBF, 4'hF);
        wr(A_FOC, 32'h0, 4'hE);
        rdr(A_FOC);
        chk(rd, 32'h3F);
        wr(A_CAL | 32'h00040000, 32'h0, 4'hF);
        chk(resp, 2'h2);
        rdr(32'h0);
        chk({rd[29:0], resp}, 32'h2);
        rdr(A_CAL);
        chk(rd, 32'h34);
        for (k = 0; k < 40; k = k + 1) begin
            foc = $urandom & 8'h3F;
            bsc = $urandom;
            if (k == 0) begin
                foc = 8'h1F;
                bsc = 8'hFF;
            end
            wr(A_FOC, {24'h0, foc}, 4'hF);
            wr(A_BSC, {24'h0, bsc}, 4'hF);
            sync <= $urandom;
            cd <= $urandom;
            repeat (5) @(posedge aclk);
            chk(frz, foc[5] & ~cd);
            chk(fg, eg(foc[4:3], foc[2], 4'h1, sync, foc[5] & ~cd));
            chk(kig, eg(bsc[7:6], bsc[3], 4'h1, sync, foc[5] & ~cd));
            chk(kpg, eg(bsc[5:4], bsc[2], 4'h2, sync, foc[5] & ~cd));
            chk(fsat, foc[1:0]);
            chk(rsat, bsc[1:0]);
        end
        for (m = 0; m < 4; m = m + 1) begin
            wr(A_CAL, {26'h0, m[1:0], 4'h4}, 4'hF);
            k = n_cal;
            pulse(1'b0);
            chk(n_cal - k, m == 1);
            k = n_cal;
            repeat (8) pulse(1'b1);
            chk(n_cal - k, (m == 2) ? 8 : (m == 3) ? 2 : 0);
        end
        // still in every-fourth mode: one return leaves the count at one
        pulse(1'b1);
        rdr(A_STAT);
        chk(rd, {28'h0, foc[5] & ~cd, sync, 2'h1});
        wr(A_CAL, 32'h04, 4'hF);
        k = n_cal;
        wr(A_CTL, 32'h1, 4'hF);
        repeat (8) @(posedge aclk);
        chk(n_cal - k, 1);
        stop_test;
    end
endmodule // test_rsl_sync_loop_cfg
